// [rtl/tdq_defines.svh]
/*
 * constants for the transmit done-queue writer: register offsets, field
 * positions, reset values and timing figures.
 * assumes inclusion by bare name from the package and the design module.
 */
// Function
// R01: read pointer equal to write pointer means the done queue is empty.
// R02: only the device changes write pointer, only the host the read pointer; here the host may also write it while master enable is clear.
// R03: queue is full when read pointer is one slot ahead of write pointer.
// R04: no completion is written until the transmit dma master enable is set.
// R05: memory address is base address plus current write pointer.
// R06: after each entry is written the write pointer advances by one dword.
// R07: advanced pointer beyond end address is replaced by zero.
// R08: write flag set after 1,2,4..128 entries as the threshold code says.
// R09: a write that would overflow sets the error flag and is skipped.
// R10: each status flag raises the interrupt when its enable is set.
// R11: burst mode gathers entries in the fifo, then writes them together.
// R12: burst enable one writes in bursts, zero writes each entry alone.
// R13: flush bit high empties the fifo into the queue; host keeps it low.
// R14: sixteen-bit flush timer decrements once every 256 bus clocks.
// R15: flush timer is used only while burst writing is enabled.
// R16: every queue write reloads the flush timer from the programmed count.
// R17: programmed count 0001h gives one tick, FFFFh gives 65,536 ticks.
// R18: host programs a nonzero timer count before setting burst enable.
// R19: timer reaching zero with entries held writes them and reloads.
`ifndef TDQ_DEFINES_SVH
`define TDQ_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define TDQ_OFS_BASE_LOW    12'h830
`define TDQ_OFS_BASE_HIGH   12'h834
`define TDQ_OFS_END_ADDR    12'h838
`define TDQ_OFS_READ_PTR    12'h83c
`define TDQ_OFS_WRITE_PTR   12'h840
`define TDQ_OFS_FLUSH_TIMER 12'h844
`define TDQ_OFS_QUEUES_CTL  12'h880
`define TDQ_OFS_MASTER_CTL  12'h890
`define TDQ_OFS_STATUS      12'h894
`define TDQ_OFS_STATUS_CLR  12'h898
`define TDQ_OFS_INT_ENABLE  12'h89c

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define TDQ_CTL_BURST_BIT   3
`define TDQ_CTL_FLUSH_BIT   4
`define TDQ_CTL_THR_LSB     8
`define TDQ_CTL_MASK        16'h071f
`define TDQ_STS_WRITE_BIT   0
`define TDQ_STS_ERROR_BIT   1
`define TDQ_RESET_16        16'h0000
`define TDQ_PTR_STEP        16'h0001
`define TDQ_DWORD_SHIFT     2
`define TDQ_PRESCALE_MAX    8'hff
`define TDQ_ONE_TICK        17'h00001

`endif

// [rtl/tdq_pkg.sv]
/*
 * types for the transmit done-queue writer.
 * assumes tdq_defines.svh on the include path.
 */
`include "tdq_defines.svh"

package tdq_pkg;

    // one memory write request toward the system bus master
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } tdq_mem_req_t;

    // status flags, same layout for status, clear and enable
    typedef struct packed {
        logic error;
        logic write;
    } tdq_flags_t;

    typedef enum logic [1:0] {
        TDQ_IDLE,
        TDQ_WRITE,
        TDQ_WAIT
    } tdq_state_t;

endpackage : tdq_pkg

// [rtl/tdq_writer.sv]
/*
 * transmit done-queue writer: keeps the circular completion queue in host
 * memory, single or burst writes through an internal fifo, flush timer,
 * write and write-error status with one level interrupt, apb registers.
 * assumes an apb master on clk_in and a memory master that accepts one
 * word per mem_ready_in handshake; the descriptor source is on clk_in.
 */
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "tdq_defines.svh"

module tdq_writer #(
    parameter int FIFO_DEPTH = 16,
    parameter int PTR_W      = 16
) (
    input  wire logic                 clk_in,
    input  wire logic                 reset_in,
    input  wire logic                 clk_en_in,
    // apb slave
    input  wire logic                 psel_in,
    input  wire logic                 penable_in,
    input  wire logic                 pwrite_in,
    input  wire logic [11:0]          paddr_in,
    input  wire logic [31:0]          pwdata_in,
    output logic      [31:0]          prdata_out,
    output logic                      pready_out,
    output logic                      pslverr_out,
    // completion descriptors from the transmit dma
    input  wire logic                 done_valid_in,
    input  wire logic [31:0]          done_desc_in,
    output logic                      done_ready_out,
    // memory write master
    output tdq_pkg::tdq_mem_req_t     mem_req_out,
    output logic                      mem_valid_out,
    input  wire logic                 mem_ready_in,
    output logic                      burst_active_out,
    output logic                      irq_out
);

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    localparam int CW = $clog2(FIFO_DEPTH + 1);
    localparam int AW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

    logic [15:0]         base_low;
    logic [15:0]         base_high;
    logic [PTR_W-1:0]    end_addr;
    logic [PTR_W-1:0]    read_ptr;
    logic [PTR_W-1:0]    write_ptr;
    logic [15:0]         flush_count;
    logic [15:0]         queues_ctl;
    logic                tx_dma_master_enable;
    tdq_pkg::tdq_flags_t status;
    tdq_pkg::tdq_flags_t int_enable;
    logic [7:0]          prescale;
    logic [16:0]         timer;
    logic [7:0]          write_count;
    tdq_pkg::tdq_state_t state;
    logic [31:0]         fifo_mem [FIFO_DEPTH];
    logic [AW-1:0]       rd_idx;
    logic [AW-1:0]       wr_idx;
    logic [CW-1:0]       fill;

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    // threshold code to number of writes, 1 to 128
    function automatic logic [7:0] thr_count(input logic [2:0] code);
        thr_count = 8'h01 << code;
    endfunction : thr_count

    // pointer after one dword, with wrap past the end address
    function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p,
                                                  input logic [PTR_W-1:0] e);
        logic [PTR_W:0] inc;
        inc = {1'b0, p} + (PTR_W+1)'(`TDQ_PTR_STEP);
        if (inc > {1'b0, e}) begin
            ptr_next = PTR_W'(`TDQ_RESET_16);                    // [R07]
        end else begin
            ptr_next = inc[PTR_W-1:0];                           // [R06]
        end
    endfunction : ptr_next

    wire logic       burst_en  = queues_ctl[`TDQ_CTL_BURST_BIT];
    wire logic       flush_bit = queues_ctl[`TDQ_CTL_FLUSH_BIT];
    wire logic [2:0] thr_code  = queues_ctl[`TDQ_CTL_THR_LSB +: 3];

    wire logic apb_access = psel_in && penable_in;
    wire logic apb_wr     = apb_access && pwrite_in;

    // ---------------------------------------------------------------
    // fifo and write sequencing
    // ---------------------------------------------------------------
    wire logic fifo_empty = (fill == '0);
    wire logic fifo_full  = (fill == CW'(FIFO_DEPTH));
    wire logic [PTR_W-1:0] next_write_ptr = ptr_next(write_ptr, end_addr);
    // queue full: advancing would land on the read pointer
    wire logic queue_full = (next_write_ptr == read_ptr);        // [R03]
    // empty when the two pointers match; kept for the status read
    wire logic queue_empty = (read_ptr == write_ptr);            // [R01]
    wire logic timer_zero  = (timer == '0);

    // drain start: single mode drains every entry, burst waits for a
    // full fifo, the flush bit, or timer expiry
    wire logic drain_start = tx_dma_master_enable && !fifo_empty &&      // [R04]
                             (!burst_en                                  // [R12]
                              || fifo_full                               // [R11]
                              || flush_bit                               // [R13]
                              || timer_zero);                            // [R15] [R19]

    // one entry leaves the fifo: written or dropped on overflow
    // a ready memory must not count a word that the full queue refused
    wire logic take_write = (state == tdq_pkg::TDQ_WRITE) && mem_ready_in && !queue_full;
    wire logic skip_write = (state == tdq_pkg::TDQ_WRITE) && queue_full; // [R09]
    wire logic pop        = take_write || skip_write;
    wire logic push       = done_valid_in && !fifo_full;
    wire logic last_pop   = pop && (fill == CW'(1));

    assign done_ready_out = !fifo_full;

    // fifo storage
    always_ff @(posedge clk_in) begin
        if (clk_en_in && push) begin
            fifo_mem[wr_idx] <= done_desc_in;
        end
    end

    // fifo indices and fill level
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rd_idx <= '0;
            wr_idx <= '0;
            fill   <= '0;
        end else if (clk_en_in) begin
            if (push) begin
                wr_idx <= (wr_idx == AW'(FIFO_DEPTH - 1)) ? '0 : wr_idx + AW'(1);
            end
            if (pop) begin
                rd_idx <= (rd_idx == AW'(FIFO_DEPTH - 1)) ? '0 : rd_idx + AW'(1);
            end
            fill <= fill + CW'(push) - CW'(pop);
        end
    end

    // sequencer: a burst runs until the fifo has drained
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state <= tdq_pkg::TDQ_IDLE;
        end else if (clk_en_in) begin
            case (state)
                tdq_pkg::TDQ_IDLE: begin
                    if (drain_start) begin
                        state <= tdq_pkg::TDQ_WRITE;
                    end
                end
                tdq_pkg::TDQ_WRITE: begin
                    if (last_pop || (pop && !burst_en)) begin
                        state <= tdq_pkg::TDQ_WAIT;
                    end
                end
                tdq_pkg::TDQ_WAIT: begin
                    state <= tdq_pkg::TDQ_IDLE;
                end
                default: begin
                    state <= tdq_pkg::TDQ_IDLE;
                end
            endcase
        end
    end

    // memory request: base plus pointer in dwords, head of fifo as data
    always_comb begin
        mem_req_out.addr = {base_high, base_low} +
                           (32'(write_ptr) << `TDQ_DWORD_SHIFT); // [R05]
        mem_req_out.data = fifo_mem[rd_idx];
    end
    assign mem_valid_out    = (state == tdq_pkg::TDQ_WRITE) && !queue_full;
    assign burst_active_out = (state == tdq_pkg::TDQ_WRITE) && burst_en;

    // write pointer: device owns it once running, host may set it at init
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            write_ptr <= '0;
        end else if (clk_en_in) begin
            if (take_write) begin
                write_ptr <= next_write_ptr;                     // [R06] [R02]
            end else if (apb_wr && !tx_dma_master_enable &&
                         paddr_in == `TDQ_OFS_WRITE_PTR) begin
                write_ptr <= pwdata_in[PTR_W-1:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // flush timer
    // ---------------------------------------------------------------
    // prescaler divides the bus clock by 256
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            prescale <= '0;
        end else if (clk_en_in) begin
            prescale <= prescale + 8'h01;                        // [R14]
        end
    end

    // count holds programmed value, FFFFh loads as 65,536; 0 would be illegal,
    // the host must avoid it before enabling bursts
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            timer <= '0;
        end else if (clk_en_in) begin
            if (take_write || !burst_en || (state == tdq_pkg::TDQ_WAIT)) begin
                timer <= 17'(flush_count) + ((flush_count == 16'hffff) ?
                         `TDQ_ONE_TICK : 17'h0);                 // [R16] [R17] [R18]
            end else if (prescale == `TDQ_PRESCALE_MAX && !timer_zero) begin
                timer <= timer - `TDQ_ONE_TICK;                  // [R14] [R15]
            end
        end
    end

    // ---------------------------------------------------------------
    // status, threshold and interrupt
    // ---------------------------------------------------------------
    wire logic clr_wr = apb_wr && paddr_in == `TDQ_OFS_STATUS_CLR;
    wire logic thr_hit = take_write &&
                         (write_count + 8'h01 >= thr_count(thr_code)); // [R08]

    // writes since the flag was last raised
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            write_count <= '0;
        end else if (clk_en_in && take_write) begin
            write_count <= thr_hit ? 8'h00 : write_count + 8'h01;
        end
    end

    // sticky flags; a set in the clearing cycle wins
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            status <= '0;
        end else if (clk_en_in) begin
            status.write <= thr_hit ||
                (status.write && !(clr_wr && pwdata_in[`TDQ_STS_WRITE_BIT])); // [R08]
            status.error <= skip_write ||
                (status.error && !(clr_wr && pwdata_in[`TDQ_STS_ERROR_BIT])); // [R09]
        end
    end

    assign irq_out = |(status & int_enable);                     // [R10]

    // ---------------------------------------------------------------
    // apb registers
    // ---------------------------------------------------------------
    // zero wait states; unmapped addresses answer with pslverr
    function automatic logic mapped(input logic [11:0] a);
        case (a)
            `TDQ_OFS_BASE_LOW, `TDQ_OFS_BASE_HIGH, `TDQ_OFS_END_ADDR,
            `TDQ_OFS_READ_PTR, `TDQ_OFS_WRITE_PTR, `TDQ_OFS_FLUSH_TIMER,
            `TDQ_OFS_QUEUES_CTL, `TDQ_OFS_MASTER_CTL, `TDQ_OFS_STATUS,
            `TDQ_OFS_STATUS_CLR, `TDQ_OFS_INT_ENABLE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction : mapped

    assign pready_out  = 1'b1;
    assign pslverr_out = apb_access && !mapped(paddr_in);

    // host-writable configuration
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            base_low             <= `TDQ_RESET_16;
            base_high            <= `TDQ_RESET_16;
            end_addr             <= '0;
            read_ptr             <= '0;
            flush_count          <= `TDQ_RESET_16;
            queues_ctl           <= `TDQ_RESET_16;
            tx_dma_master_enable <= 1'b0;
            int_enable           <= '0;
        end else if (clk_en_in && apb_wr) begin
            case (paddr_in)
                `TDQ_OFS_BASE_LOW:    base_low    <= pwdata_in[15:0];
                `TDQ_OFS_BASE_HIGH:   base_high   <= pwdata_in[15:0];
                `TDQ_OFS_END_ADDR:    end_addr    <= pwdata_in[PTR_W-1:0];
                `TDQ_OFS_READ_PTR:    read_ptr    <= pwdata_in[PTR_W-1:0]; // [R02]
                `TDQ_OFS_FLUSH_TIMER: flush_count <= pwdata_in[15:0];
                `TDQ_OFS_QUEUES_CTL:  queues_ctl  <= pwdata_in[15:0] & `TDQ_CTL_MASK;
                `TDQ_OFS_MASTER_CTL:  tx_dma_master_enable <= pwdata_in[0];
                `TDQ_OFS_INT_ENABLE:  int_enable  <= pwdata_in[1:0];
                default: ;
            endcase
        end
    end

    // read data registered at the access phase edge is too late for a
    // zero-wait slave, so read data is driven from register contents
    always_comb begin
        prdata_out = 32'h0;
        if (apb_access && !pwrite_in) begin
            case (paddr_in)
                `TDQ_OFS_BASE_LOW:    prdata_out = {16'h0, base_low};
                `TDQ_OFS_BASE_HIGH:   prdata_out = {16'h0, base_high};
                `TDQ_OFS_END_ADDR:    prdata_out = 32'(end_addr);
                `TDQ_OFS_READ_PTR:    prdata_out = 32'(read_ptr);
                `TDQ_OFS_WRITE_PTR:   prdata_out = 32'(write_ptr);
                `TDQ_OFS_FLUSH_TIMER: prdata_out = {16'h0, flush_count};
                `TDQ_OFS_QUEUES_CTL:  prdata_out = {16'h0, queues_ctl};
                `TDQ_OFS_MASTER_CTL:  prdata_out = {31'h0, tx_dma_master_enable};
                `TDQ_OFS_STATUS:      prdata_out = {29'h0, queue_empty, status};
                `TDQ_OFS_INT_ENABLE:  prdata_out = {30'h0, int_enable};
                default:              prdata_out = 32'h0;
            endcase
        end
    end

endmodule : tdq_writer

// [bench/tdq_host_mem.sv]
/* host memory model for the done-queue writer: accepts and logs memory words.
   assumes the writer's memory port on the same clock; slow_in stalls alternate cycles. */
`timescale 1ns/1ps
// ---------------------------------------------
// memory slave, prompt or slow
// ---------------------------------------------
module tdq_host_mem (
    input  wire logic                  clk_in,
    input  wire logic                  reset_in,
    input  wire logic                  slow_in,
    input  wire tdq_pkg::tdq_mem_req_t mem_req_in,
    input  wire logic                  mem_valid_in,
    output logic                       mem_ready_out
);
    logic                  tick;
    tdq_pkg::tdq_mem_req_t log_q[$];
    // stalling every other cycle makes the writer hold its request
    assign mem_ready_out = slow_in ? tick : 1'b1;
    // memory only stores words; the read pointer moves by the host alone
    always @(posedge clk_in) begin
        tick <= reset_in ? 1'b0 : ~tick;
        if (!reset_in && mem_valid_in && mem_ready_out) log_q.push_back(mem_req_in);
    end
endmodule : tdq_host_mem

// [bench/tdq_writer_properties.sv]
/* port checker for the done-queue writer, bound to its top module.
   assumes apb writes take effect at the access edge while clk_en_in is high. */
`timescale 1ns/1ps
// ---------------------------------------------
// shadow of queue registers and assertions
// ---------------------------------------------
module tdq_writer_checker #(
    parameter int FIFO_DEPTH = 16,
    parameter int PTR_W      = 16
) (
    input wire logic                  clk_in,
    input wire logic                  reset_in,
    input wire logic                  clk_en_in,
    input wire logic                  psel_in,
    input wire logic                  penable_in,
    input wire logic                  pwrite_in,
    input wire logic [11:0]           paddr_in,
    input wire logic [31:0]           pwdata_in,
    input wire logic                  pready_out,
    input wire logic                  pslverr_out,
    input wire tdq_pkg::tdq_mem_req_t mem_req_out,
    input wire logic                  mem_valid_out,
    input wire logic                  mem_ready_in,
    input wire logic                  burst_active_out,
    input wire logic                  irq_out
);
    logic [31:0]      base;
    logic [15:0]      endp, rp;
    logic [PTR_W-1:0] wp, nwp;
    logic             men, burst;
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // pointer after the current slot, wrapping past the end address
    assign nwp = (32'(wp) + 1 > 32'(endp)) ? '0 : wp + 1'b1;
    // shadow kept from bus writes so addresses can be predicted
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            {base, endp, rp, wp, men, burst} <= '0;
        end else if (clk_en_in) begin
            if (mem_valid_out && mem_ready_in) wp <= nwp;
            if (psel_in && penable_in && pwrite_in) begin
                case (paddr_in)
                    12'h830: base[15:0] <= pwdata_in[15:0];
                    12'h834: base[31:16] <= pwdata_in[15:0];
                    12'h838: endp <= pwdata_in[15:0];
                    12'h83c: rp <= pwdata_in[15:0];
                    12'h840: if (!men) wp <= pwdata_in[PTR_W-1:0];
                    12'h880: burst <= pwdata_in[3];
                    12'h890: men <= pwdata_in[0];
                    default: ;
                endcase
            end
        end
    end
    property p_addr; mem_valid_out |-> mem_req_out.addr == base + (32'(wp) << 2); endproperty
    a_addr: assert property (p_addr) else $error("memory address wrong");
    property p_full; mem_valid_out |-> nwp != PTR_W'(rp); endproperty
    a_full: assert property (p_full) else $error("write into full queue");
    property p_enable; !men |-> !mem_valid_out; endproperty
    a_enable: assert property (p_enable) else $error("write while disabled");
    property p_hold; mem_valid_out && !mem_ready_in |=> mem_valid_out && $stable(mem_req_out);
    endproperty
    a_hold: assert property (p_hold) else $error("request dropped early");
    property p_pready; psel_in && penable_in |-> pready_out; endproperty
    a_pready: assert property (p_pready) else $error("no ready");
    property p_slverr; psel_in && penable_in |-> pslverr_out == !(paddr_in inside
        {12'h830, 12'h834, 12'h838, 12'h83c, 12'h840, 12'h844, 12'h880, 12'h890, 12'h894,
         12'h898, 12'h89c});
    endproperty
    a_slverr: assert property (p_slverr) else $error("error response wrong");
    property p_single; !burst && mem_valid_out && mem_ready_in && clk_en_in |=>
        !mem_valid_out [*2]; endproperty
    a_single: assert property (p_single) else $error("single write not alone");
    property p_burst; (!burst |-> !burst_active_out) and
        (burst && mem_valid_out |-> burst_active_out); endproperty
    a_burst: assert property (p_burst) else $error("burst without enable");
    property p_rst; $fell(reset_in) |-> !irq_out && !mem_valid_out; endproperty
    a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule : tdq_writer_checker

bind tdq_writer tdq_writer_checker #(.FIFO_DEPTH(FIFO_DEPTH), .PTR_W(PTR_W)) u_chk (.*);

// [bench/test_tdq_writer.sv]
/* self-checking bench for the done-queue writer: apb tasks, descriptor pushes,
   memory log compared with predicted addresses. assumes tdq_host_mem and the checker. */
`timescale 1ns/1ps
// ---------------------------------------------
// bench top
// ---------------------------------------------
module test_tdq_writer;
    logic clk_in = 0, reset_in = 1, clk_en_in = 1, psel_in = 0, penable_in = 0;
    logic pwrite_in = 0, done_valid_in = 0, mem_slow = 0, serr, pready_out, pslverr_out;
    logic done_ready_out, mem_valid_out, mem_ready_in, burst_active_out, irq_out;
    logic [11:0] paddr_in = '0;
    logic [31:0] pwdata_in = '0, done_desc_in = '0, prdata_out, rd, seq = 32'h00c0_0000;
    logic [31:0] base = 32'h1234_5600, exp_q[$];
    logic [15:0] wp = '0, endp = 16'h0003;
    int          bad_count = 0, cmp_count = 0, cyc = 0, seen = 0;
    tdq_pkg::tdq_mem_req_t mem_req_out;

    tdq_writer u_tdq_writer (.*);
    tdq_host_mem u_host_mem (.clk_in(clk_in), .reset_in(reset_in), .slow_in(mem_slow),
        .mem_req_in(mem_req_out), .mem_valid_in(mem_valid_out), .mem_ready_out(mem_ready_in));

    always #25 clk_in = ~clk_in;
    // hang guard, well above the few thousand cycles the run needs
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            print_verdict();
        end
    end

    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // setup cycle, then access until pready; starts one edge after any release
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'b1; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        serr = pslverr_out;
        psel_in <= 1'b0; penable_in <= 1'b0;
    endtask : apb

    task rdc(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        chk(n, e, rd);
    endtask : rdc

    // offer n descriptors, each held until taken
    task push(input int n);
        @(posedge clk_in);
        repeat (n) begin
            seq++;
            exp_q.push_back(seq);
            done_valid_in <= 1'b1; done_desc_in <= seq;
            @(posedge clk_in);
            while (done_ready_out !== 1'b1) @(posedge clk_in);
        end
        done_valid_in <= 1'b0;
    endtask : push

    // wait for n memory words, compare address, data and count
    task expect_mem(input int n, input int lim);
        int k;
        k = 0;
        while (u_host_mem.log_q.size() < seen + n && k < lim) begin
            @(posedge clk_in);
            k++;
        end
        repeat (n) begin
            chk("mem addr", base + {wp, 2'b00}, u_host_mem.log_q[seen].addr);
            chk("mem data", exp_q.pop_front(), u_host_mem.log_q[seen].data);
            seen++;
            wp = (wp + 16'h0001 > endp) ? '0 : wp + 16'h0001;
        end
        chk("mem count", 32'(seen), 32'(u_host_mem.log_q.size()));
    endtask : expect_mem

    initial begin
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        rdc("flush timer", 12'h844, '0);
        rdc("queues ctl", 12'h880, '0);
        apb(1'b0, 12'h8a0, '0);
        chk("unmapped err", 1, {31'b0, serr});
        apb(1'b1, 12'h830, 32'h5600); apb(1'b1, 12'h834, 32'h1234); apb(1'b1, 12'h838, 3);
        push(1);
        repeat (20) @(posedge clk_in);
        expect_mem(0, 0);
        apb(1'b1, 12'h890, 1);
        expect_mem(1, 50);
        push(3);
        expect_mem(2, 100);
        repeat (30) @(posedge clk_in);
        exp_q.delete();
        expect_mem(0, 0);
        rdc("write ptr", 12'h840, 3);
        rdc("status", 12'h894, 3);
        chk("irq masked", 0, {31'b0, irq_out});
        apb(1'b1, 12'h89c, 2);
        repeat (2) @(posedge clk_in);
        chk("irq raised", 1, {31'b0, irq_out});
        apb(1'b1, 12'h898, 3);
        repeat (2) @(posedge clk_in);
        chk("irq cleared", 0, {31'b0, irq_out});
        // host catches up; next two entries fill the last slot, then wrap to slot zero
        apb(1'b1, 12'h83c, 3);
        rdc("status empty", 12'h894, 4);
        push(2);
        expect_mem(2, 100);
        apb(1'b1, 12'h840, 32'h55);
        rdc("write ptr kept", 12'h840, 1);
        endp = 16'h00ff;
        apb(1'b1, 12'h838, 32'hff);
        for (int c = 1; c < 8; c++) begin
            apb(1'b1, 12'h83c, 32'(wp)); apb(1'b1, 12'h898, 1); apb(1'b1, 12'h880, c << 8);
            push((1 << c) - 1);
            expect_mem((1 << c) - 1, 8 << c);
            apb(1'b0, 12'h894, '0);
            chk("flag early", 0, rd & 32'h1);
            push(1);
            expect_mem(1, 50);
            apb(1'b0, 12'h894, '0);
            chk("flag set", 1, rd & 32'h1);
        end
        // burst: timer of 2 ticks holds entries at least 257 cycles
        apb(1'b1, 12'h880, 0); apb(1'b1, 12'h83c, 32'(wp)); apb(1'b1, 12'h844, 2);
        mem_slow <= 1'b1;
        apb(1'b1, 12'h880, 8);
        push(4);
        repeat (240) @(posedge clk_in);
        expect_mem(0, 0);
        expect_mem(4, 600);
        apb(1'b1, 12'h880, 0); apb(1'b1, 12'h844, 32'hffff); apb(1'b1, 12'h880, 8);
        push(3);
        repeat (50) @(posedge clk_in);
        expect_mem(0, 0);
        apb(1'b1, 12'h880, 32'h18);
        expect_mem(3, 100);
        apb(1'b1, 12'h880, 8);
        push(16);
        expect_mem(16, 200);
        // frozen clock enable ignores register writes
        clk_en_in <= 1'b0;
        apb(1'b1, 12'h838, 7);
        clk_en_in <= 1'b1;
        rdc("end kept", 12'h838, 32'hff);
        print_verdict();
    end
endmodule : test_tdq_writer
